// file: hdl/daic_top.sv
// Dual analog input conditioner: sequencing, scaling, registers
//
// How it works
// - Filter only when bus cycle exceeds 500 us
// - Filtered: 1 ms sampling, channel 2 200 us later
// - Filtered sampling runs on own free timebase
// - Unfiltered: capture at fixed network cycle offset
// - Ramp limit only with filter, before filter
// - Oversized step moves tracked value by limit
// - Config bits 4-6 choose ramp limit
// - New equals old minus old/N plus input/N
// - Config bits 0-2 choose filter level 2^n
// - Filter config resets to zero
// - Type bits 0/1 choose voltage or current
// - Bits 4/5 choose 0-20 or 4-20 mA
// - Input switch driven from channel type
// - Signed 16-bit encoding per range
// - Default limits 7FFF upper, mode-dependent lower
// - Current mode defaults clamp at zero
// - Shared limits take effect on write
// - Later values compared against new limits
// - Passing a limit holds value and flags
// - Two status bits per channel, change event
// - Error substitutes fixed default values
`include "daic_defines.svh"

module daic_top #(
  parameter int MIN_FILT_CYC_CLKS = `DAIC_MIN_FILT_CYC_CLKS,
  parameter int SAMPLE_CLKS       = `DAIC_SAMPLE_CLKS,
  parameter int CH2_DELAY_CLKS    = `DAIC_CH2_DELAY_CLKS,
  parameter int CAPTURE_OFS_CLKS  = `DAIC_CAPTURE_OFS_CLKS,
  parameter int CNT_W             = 20
) (
  input  wire logic               clock,
  input  wire logic               rst,
  input  wire logic               net_sync,
  input  wire logic [4:0]         reg_addr,
  input  wire logic               reg_wr,
  input  wire logic [15:0]        reg_wdata,
  input  wire logic               reg_rd,
  output logic [15:0]             reg_rdata,
  output logic                    reg_rvalid,
  output logic                    conv_start,
  output logic                    conv_chan,
  input  wire logic               conv_done,
  input  wire logic signed [15:0] conv_data,
  input  wire logic               conv_open_line,
  input  wire logic               conv_invalid,
  output logic [1:0]              sel_current,
  output logic [1:0]              range_4_20,
  output logic                    error_event
);

  // ========================================================================
  // Configuration registers
  logic [7:0]         filt_cfg_q;
  logic [7:0]         cht_cfg_q;
  logic signed [15:0] lower_q;
  logic signed [15:0] upper_q;
  logic               lower_set_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      filt_cfg_q  <= `DAIC_FILT_CFG_RST;
      cht_cfg_q   <= `DAIC_CHT_CFG_RST;
      lower_q     <= `DAIC_LOWER_DEF_VOLT;
      upper_q     <= `DAIC_UPPER_DEF;
      lower_set_q <= 1'b0;
    end else if (reg_wr) begin
      case (reg_addr)
        `DAIC_OFS_FILT_CFG:
          filt_cfg_q <= reg_wdata[7:0] & `DAIC_FILT_CFG_MASK;
        `DAIC_OFS_CHTYPE_CFG:
          cht_cfg_q <= reg_wdata[7:0] & `DAIC_CHT_CFG_MASK;
        `DAIC_OFS_LOWER_LIM: begin
          lower_q     <= reg_wdata;
          lower_set_q <= 1'b1;
        end
        `DAIC_OFS_UPPER_LIM:
          upper_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  logic [2:0] level;
  logic [2:0] ramp_code;
  logic [1:0] is_cur;
  logic [1:0] is_420;

  assign level     = filt_cfg_q[`DAIC_FILT_LEVEL_LSB +: 3];
  assign ramp_code = filt_cfg_q[`DAIC_FILT_RAMP_LSB +: 3];
  assign is_cur    = {cht_cfg_q[`DAIC_CHT_CUR_CH2],
                      cht_cfg_q[`DAIC_CHT_CUR_CH1]};
  assign is_420    = {cht_cfg_q[`DAIC_CHT_RNG_CH2],
                      cht_cfg_q[`DAIC_CHT_RNG_CH1]} & is_cur;

  // Switch drive follows configuration with no further request
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sel_current <= 2'b00;
      range_4_20  <= 2'b00;
    end else begin
      sel_current <= is_cur;
      range_4_20  <= is_420;
    end
  end

  // ========================================================================
  // Network cycle measurement
  // Saturating count; only its comparison against the threshold matters
  logic [CNT_W-1:0] cyc_cnt_q;
  logic             cycle_long_q;
  logic             filt_active;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cyc_cnt_q    <= '0;
      cycle_long_q <= 1'b0;
    end else if (net_sync) begin
      cycle_long_q <= cyc_cnt_q > CNT_W'(MIN_FILT_CYC_CLKS);
      cyc_cnt_q    <= CNT_W'(1);
    end else if (cyc_cnt_q != '1) begin
      cyc_cnt_q <= cyc_cnt_q + CNT_W'(1);
    end
  end

  assign filt_active = (level != 3'd0) && cycle_long_q;

  // ========================================================================
  // Sample timing
  logic [CNT_W-1:0] tick_cnt_q;
  logic [CNT_W-1:0] ofs_cnt_q;
  logic             ofs_run_q;
  logic [1:0]       req;

  // Free-running tick, never reloaded by net_sync
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tick_cnt_q <= '0;
    end else if (tick_cnt_q == CNT_W'(SAMPLE_CLKS - 1)) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + CNT_W'(1);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ofs_cnt_q <= '0;
      ofs_run_q <= 1'b0;
    end else if (net_sync) begin
      ofs_cnt_q <= '0;
      ofs_run_q <= 1'b1;
    end else if (ofs_run_q) begin
      ofs_cnt_q <= ofs_cnt_q + CNT_W'(1);
      if (ofs_cnt_q == CNT_W'(CAPTURE_OFS_CLKS)) begin
        ofs_run_q <= 1'b0;
      end
    end
  end

  always_comb begin
    if (filt_active) begin
      req[0] = tick_cnt_q == '0;
      req[1] = tick_cnt_q == CNT_W'(CH2_DELAY_CLKS);
    end else begin
      // Both channels captured back to back after the offset
      req[0] = ofs_run_q && (ofs_cnt_q == CNT_W'(CAPTURE_OFS_CLKS));
      req[1] = req[0];
    end
  end

  // ========================================================================
  // Converter sequencer
  // One conversion outstanding; further requests wait in pend_q
  daic_pkg::daic_seq_e seq_q;
  logic [1:0]          pend_q;
  logic                cur_ch_q;
  logic                issue;
  logic                issue_ch;

  assign issue    = (seq_q == daic_pkg::DAIC_SQ_IDLE) && (pend_q != 2'b00);
  assign issue_ch = !pend_q[0];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pend_q <= 2'b00;
    end else begin
      // New request wins over the clear of the same bit
      pend_q <= (pend_q & ~({issue && issue_ch, issue && !issue_ch})) | req;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      seq_q      <= daic_pkg::DAIC_SQ_IDLE;
      cur_ch_q   <= 1'b0;
      conv_start <= 1'b0;
      conv_chan  <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      case (seq_q)
        daic_pkg::DAIC_SQ_IDLE: begin
          if (issue) begin
            seq_q      <= daic_pkg::DAIC_SQ_BUSY;
            cur_ch_q   <= issue_ch;
            conv_start <= 1'b1;
            conv_chan  <= issue_ch;
          end
        end
        daic_pkg::DAIC_SQ_BUSY: begin
          if (conv_done) begin
            seq_q <= daic_pkg::DAIC_SQ_IDLE;
          end
        end
        default: seq_q <= daic_pkg::DAIC_SQ_IDLE;
      endcase
    end
  end

  // ========================================================================
  // Range encoding
  // Converter delivers current as 0..32767 for 0..20 mA
  logic signed [17:0] raw;
  logic signed [17:0] scaled;
  logic signed [15:0] coded;
  logic               ch_cur;
  logic               ch_420;

  assign ch_cur = is_cur[cur_ch_q];
  assign ch_420 = is_420[cur_ch_q];

  always_comb begin
    raw    = 18'(conv_data);
    scaled = raw;
    if (ch_cur && ch_420) begin
      scaled = raw + (raw >>> 2) - $signed(18'(`DAIC_OFFSET_4MA));
    end else if (ch_cur && raw < 0) begin
      scaled = '0;
    end
    if (scaled > 18'sd32767) begin
      coded = 16'h7FFF;
    end else if (scaled < -18'sd32768) begin
      coded = 16'h8000;
    end else begin
      coded = scaled[15:0];
    end
  end

  // ========================================================================
  // Channel pipelines
  logic [1:0]         fin_valid;
  logic [1:0]         fout_valid;
  logic signed [15:0] fout_data [2];
  logic [1:0]         open_q;
  logic [1:0]         inval_q;
  logic signed [15:0] value [2];
  logic [1:0]         status [2];
  logic [1:0]         changed;
  logic signed [15:0] lower_eff [2];

  assign fin_valid[0] = (seq_q == daic_pkg::DAIC_SQ_BUSY) && conv_done
                        && !cur_ch_q;
  assign fin_valid[1] = (seq_q == daic_pkg::DAIC_SQ_BUSY) && conv_done
                        && cur_ch_q;

  for (genvar c = 0; c < 2; c++) begin : g_ch
    // Open line only detectable in voltage mode
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        open_q[c]  <= 1'b0;
        inval_q[c] <= 1'b0;
      end else if (fin_valid[c]) begin
        open_q[c]  <= conv_open_line && !is_cur[c];
        inval_q[c] <= conv_invalid;
      end
    end

    // Default lower limit depends on mode until software writes one
    assign lower_eff[c] = lower_set_q ? lower_q :
                          (is_cur[c] ? `DAIC_LOWER_DEF_CUR
                                     : `DAIC_LOWER_DEF_VOLT);

    daic_chan_filter #(.W(16)) u_filt (
      .clock     (clock),
      .rst       (rst),
      .in_valid  (fin_valid[c]),
      .in_data   (coded),
      .filt_on   (filt_active),
      .level     (level),
      .ramp_code (ramp_code),
      .out_valid (fout_valid[c]),
      .out_data  (fout_data[c])
    );

    daic_limit u_lim (
      .clock      (clock),
      .rst        (rst),
      .in_valid   (fout_valid[c]),
      .in_data    (fout_data[c]),
      .in_open    (open_q[c]),
      .in_invalid (inval_q[c]),
      .lower      (lower_eff[c]),
      .upper      (upper_q),
      .value_q    (value[c]),
      .status_q   (status[c]),
      .changed_q  (changed[c])
    );
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      error_event <= 1'b0;
    end else begin
      error_event <= |changed;
    end
  end

  // ========================================================================
  // Register reads
  // Configuration registers are write-only and read back as zero
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rdata  <= '0;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          `DAIC_OFS_VALUE_CH1: reg_rdata <= value[0];
          `DAIC_OFS_VALUE_CH2: reg_rdata <= value[1];
          `DAIC_OFS_STATUS:
            reg_rdata <= {12'h000, status[1], status[0]};
          default:             reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

endmodule : daic_top

// file: hdl/daic_defines.svh
// Offsets, field positions, reset values and timing counts of the conditioner
`ifndef DAIC_DEFINES_SVH
`define DAIC_DEFINES_SVH

// ==========================================================================
// Register byte offsets
`define DAIC_OFS_VALUE_CH1   5'h00
`define DAIC_OFS_VALUE_CH2   5'h02
`define DAIC_OFS_FILT_CFG    5'h10
`define DAIC_OFS_CHTYPE_CFG  5'h12
`define DAIC_OFS_LOWER_LIM   5'h14
`define DAIC_OFS_UPPER_LIM   5'h16
`define DAIC_OFS_STATUS      5'h1E

// ==========================================================================
// Field positions
`define DAIC_FILT_LEVEL_LSB  0
`define DAIC_FILT_RAMP_LSB   4
`define DAIC_CHT_CUR_CH1     0
`define DAIC_CHT_CUR_CH2     1
`define DAIC_CHT_RNG_CH1     4
`define DAIC_CHT_RNG_CH2     5
`define DAIC_FILT_CFG_MASK   8'h77
`define DAIC_CHT_CFG_MASK    8'h33

// ==========================================================================
// Reset values and codes
`define DAIC_FILT_CFG_RST    8'h00
`define DAIC_CHT_CFG_RST     8'h00
`define DAIC_UPPER_DEF       16'h7FFF
`define DAIC_LOWER_DEF_VOLT  16'h8001
`define DAIC_LOWER_DEF_CUR   16'h0000
`define DAIC_VAL_OPEN        16'h7FFF
`define DAIC_VAL_INVALID     16'h8000
`define DAIC_RAMP_BASE       16'h3FFF
`define DAIC_OFFSET_4MA      16'h2000

// ==========================================================================
// Timing
`define DAIC_CLK_MHZ         200
`define DAIC_MIN_FILT_CYC_US 500
`define DAIC_SAMPLE_US       1000
`define DAIC_CH2_DELAY_US    200
`define DAIC_MIN_FILT_CYC_CLKS (`DAIC_MIN_FILT_CYC_US * `DAIC_CLK_MHZ)
`define DAIC_SAMPLE_CLKS     (`DAIC_SAMPLE_US * `DAIC_CLK_MHZ)
`define DAIC_CH2_DELAY_CLKS  (`DAIC_CH2_DELAY_US * `DAIC_CLK_MHZ)
`define DAIC_CAPTURE_OFS_CLKS 16

`endif

// file: hdl/daic_pkg.sv
// Types shared by the conditioner modules
package daic_pkg;

  // ========================================================================
  // Status codes per channel
  typedef enum logic [1:0] {
    DAIC_ST_OK    = 2'b00,
    DAIC_ST_LOWER = 2'b01,
    DAIC_ST_UPPER = 2'b10,
    DAIC_ST_OPEN  = 2'b11
  } daic_status_e;

  // ========================================================================
  // Converter sequencer states
  typedef enum logic [1:0] {
    DAIC_SQ_IDLE = 2'b00,
    DAIC_SQ_BUSY = 2'b01
  } daic_seq_e;

  typedef logic signed [15:0] daic_sample_t;

endpackage : daic_pkg

// file: hdl/daic_chan_filter.sv
// Ramp limiter followed by first-order averaging filter for one channel
`include "daic_defines.svh"

module daic_chan_filter #(
  parameter int W = 16
) (
  input  wire logic                clock,
  input  wire logic                rst,
  input  wire logic                in_valid,
  input  wire logic signed [W-1:0] in_data,
  input  wire logic                filt_on,
  input  wire logic [2:0]          level,
  input  wire logic [2:0]          ramp_code,
  output logic                     out_valid,
  output logic signed [W-1:0]      out_data
);

  localparam logic signed [W+1:0] MAXV = (W+2)'((1 << (W-1)) - 1);
  localparam logic signed [W+1:0] MINV = -(W+2)'(1 << (W-1));

  logic signed [W-1:0] track_q;
  logic signed [W-1:0] filt_q;
  logic signed [W+1:0] x;
  logic signed [W+1:0] prev;
  logic signed [W+1:0] old;
  logic signed [W+1:0] diff;
  logic signed [W+1:0] lim;
  logic signed [W+1:0] tracked;
  logic signed [W+1:0] nxt;

  // ========================================================================
  // Arithmetic helpers
  // Truncation toward zero; a plain arithmetic shift would drift negative
  function automatic logic signed [W+1:0] tdiv(
    input logic signed [W+1:0] v, input logic [2:0] s);
    if (v < 0) return -((-v) >>> s);
    return v >>> s;
  endfunction : tdiv

  function automatic logic signed [W-1:0] sat(input logic signed [W+1:0] v);
    if (v > MAXV) return MAXV[W-1:0];
    if (v < MINV) return MINV[W-1:0];
    return v[W-1:0];
  endfunction : sat

  // ========================================================================
  // Ramp limit then filter update
  always_comb begin
    x    = (W+2)'(in_data);
    prev = (W+2)'(track_q);
    old  = (W+2)'(filt_q);
    diff = x - prev;
    lim  = (W+2)'({2'b00, `DAIC_RAMP_BASE} >> (ramp_code - 3'd1));
    tracked = x;
    if (ramp_code != 3'd0) begin
      if (diff > lim) begin
        tracked = prev + lim;
      end else if (diff < -lim) begin
        tracked = prev - lim;
      end
    end
    nxt = old - tdiv(old, level) + tdiv(tracked, level);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      track_q <= '0;
      filt_q  <= '0;
    end else if (in_valid) begin
      if (filt_on) begin
        track_q <= sat(tracked);
        filt_q  <= sat(nxt);
      end else begin
        // Seeding both states keeps the first filtered step from jumping
        track_q <= in_data;
        filt_q  <= in_data;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      out_valid <= 1'b0;
    end else begin
      out_valid <= in_valid;
    end
  end

  assign out_data = filt_q;

endmodule : daic_chan_filter

// file: hdl/daic_limit.sv
// Limit compare, clamp, error substitution and status for one channel
`include "daic_defines.svh"

module daic_limit (
  input  wire logic               clock,
  input  wire logic               rst,
  input  wire logic               in_valid,
  input  wire logic signed [15:0] in_data,
  input  wire logic               in_open,
  input  wire logic               in_invalid,
  input  wire logic signed [15:0] lower,
  input  wire logic signed [15:0] upper,
  output logic signed [15:0]      value_q,
  output logic [1:0]              status_q,
  output logic                    changed_q
);

  logic [1:0]        st_d;
  logic signed [15:0] val_d;

  always_comb begin
    st_d  = daic_pkg::DAIC_ST_OK;
    val_d = in_data;
    if (in_open) begin
      st_d  = daic_pkg::DAIC_ST_OPEN;
      val_d = `DAIC_VAL_OPEN;
    end else if (in_invalid) begin
      val_d = `DAIC_VAL_INVALID;
    end else if (in_data > upper) begin
      st_d  = daic_pkg::DAIC_ST_UPPER;
      val_d = upper;
    end else if (in_data < lower) begin
      st_d  = daic_pkg::DAIC_ST_LOWER;
      val_d = lower;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      value_q   <= '0;
      status_q  <= daic_pkg::DAIC_ST_OK;
      changed_q <= 1'b0;
    end else begin
      changed_q <= in_valid && (st_d != status_q);
      if (in_valid) begin
        value_q  <= val_d;
        status_q <= st_d;
      end
    end
  end

endmodule : daic_limit

// file: test/daic_top_checker.sv
// Port-level assertions for the dual analog input conditioner
module daic_top_checker (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic [4:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        reg_rvalid,
  input wire logic        conv_start,
  input wire logic        conv_chan,
  input wire logic        conv_done,
  input wire logic [1:0]  sel_current,
  input wire logic [1:0]  range_4_20,
  input wire logic        error_event
);
  timeunit 1ns;
  timeprecision 100ps;

  logic open_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // ==========================================================================
  // Helper: one conversion may be open at a time
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      open_q <= 1'b0;
    end else if (conv_start) begin
      open_q <= 1'b1;
    end else if (conv_done) begin
      open_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Assertions
  chk_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered next cycle");
  chk_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("read valid without a read");
  chk_status_spare: assert property (reg_rd && reg_addr == 5'h1E
    |=> reg_rdata[15:4] == 12'h000) else $error("status spare bits set");
  chk_rdata_hold: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data moved without a read");
  chk_start_single: assert property (conv_start |=> !conv_start)
    else $error("conversion start longer than one cycle");
  chk_one_open: assert property (conv_start |-> !open_q)
    else $error("second conversion while one is open");
  chk_chan_hold: assert property (!conv_start |-> $stable(conv_chan))
    else $error("channel select moved without a start");
  chk_switch_follow: assert property (reg_wr && reg_addr == 5'h12
    |-> ##2 sel_current == $past(reg_wdata[1:0], 2))
    else $error("input switch does not follow channel type");
  chk_range_follow: assert property (reg_wr && reg_addr == 5'h12
    && reg_wdata[1:0] == 2'b11
    |-> ##2 range_4_20 == $past(reg_wdata[5:4], 2))
    else $error("current range does not follow channel type");
  chk_event_pulse: assert property (error_event |=> !error_event)
    else $error("error event longer than one cycle");
endmodule : daic_top_checker

bind daic_top daic_top_checker i_daic_top_checker (
  .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .conv_start(conv_start), .conv_chan(conv_chan),
  .conv_done(conv_done), .sel_current(sel_current),
  .range_4_20(range_4_20), .error_event(error_event)
);

// file: test/daic_conv_model.sv
// Behavioural converter front end answering conversion starts
module daic_conv_model (
  input wire logic          clock,
  input wire logic          rst,
  input wire logic          conv_start,
  input wire logic          conv_chan,
  input wire logic [15:0]   val1,
  input wire logic [15:0]   val2,
  input wire logic          open_f,
  input wire logic          inv_f,
  input wire logic [3:0]    lat,
  output logic              conv_done,
  output logic signed [15:0] conv_data,
  output logic              conv_open_line,
  output logic              conv_invalid,
  output logic              done_chan
);
  timeunit 1ns;
  timeprecision 100ps;

  logic       busy_q;
  logic       chan_q;
  logic [3:0] cnt_q;

  // Data toggles while idle so a stale sample is never mistaken for valid
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b0;
      chan_q <= 1'b0;
      cnt_q <= 4'h0;
      conv_done <= 1'b0;
      conv_data <= 16'sh0000;
      conv_open_line <= 1'b0;
      conv_invalid <= 1'b0;
      done_chan <= 1'b0;
    end else begin
      conv_done <= 1'b0;
      conv_open_line <= 1'b0;
      conv_invalid <= 1'b0;
      conv_data <= ~conv_data;
      if (conv_start) begin
        busy_q <= 1'b1;
        chan_q <= conv_chan;
        cnt_q <= lat;
      end else if (busy_q && cnt_q == 4'h0) begin
        busy_q <= 1'b0;
        conv_done <= 1'b1;
        done_chan <= chan_q;
        conv_data <= chan_q ? val2 : val1;
        conv_open_line <= open_f;
        conv_invalid <= inv_f;
      end else if (busy_q) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule : daic_conv_model

// file: test/tb_top.sv
// Self-checking bench for the dual analog input conditioner
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        net_sync = 1'b0;
  logic [4:0]  reg_addr = 5'h00;
  logic        reg_wr = 1'b0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic        reg_rvalid, conv_start, conv_chan, conv_done, done_chan;
  logic        conv_open_line, conv_invalid, error_event;
  logic signed [15:0] conv_data;
  logic [1:0]  sel_current, range_4_20;
  logic [15:0] val1 = 16'h0000;
  logic [15:0] val2 = 16'h0000;
  logic        open_f = 1'b0;
  logic        inv_f = 1'b0;
  logic [3:0]  lat = 4'h1;
  int          sync_period = 40;
  int          sync_cnt = 0;
  int          cyc = 0;
  int          ev_cnt = 0;
  int          err_count = 0;
  int          checks = 0;
  int          n;

  // Short counts keep the run brief
  daic_top #(.MIN_FILT_CYC_CLKS(50), .SAMPLE_CLKS(200), .CH2_DELAY_CLKS(40))
  i_daic_top (.clock(clock), .rst(rst), .net_sync(net_sync),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .conv_start(conv_start), .conv_chan(conv_chan), .conv_done(conv_done),
    .conv_data(conv_data), .conv_open_line(conv_open_line),
    .conv_invalid(conv_invalid), .sel_current(sel_current),
    .range_4_20(range_4_20), .error_event(error_event));

  daic_conv_model i_daic_conv_model (.clock(clock), .rst(rst),
    .conv_start(conv_start), .conv_chan(conv_chan), .val1(val1),
    .val2(val2), .open_f(open_f), .inv_f(inv_f), .lat(lat),
    .conv_done(conv_done), .conv_data(conv_data),
    .conv_open_line(conv_open_line), .conv_invalid(conv_invalid),
    .done_chan(done_chan));

  // ==========================================================================
  // Clock, network cycle, event count and time limit
  always #2.5 clock = ~clock;

  always @(posedge clock) begin
    #1;
    sync_cnt = (sync_cnt + 1) % sync_period;
    net_sync = (sync_cnt == 0) && !rst;
    cyc++;
    if (error_event === 1'b1) ev_cnt++;
    if (cyc == 60000) begin
      err_count++;
      print_verdict();
    end
  end

  // ==========================================================================
  // Tasks
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clock);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clock);
    #1;
    reg_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    @(posedge clock);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clock);
    #1;
    reg_rd = 1'b0;
    check({15'h0000, reg_rvalid}, 16'h0001);
    check(reg_rdata, exp);
  endtask : rd

  // Waits for k results of channel 1, then lets the value settle
  task automatic wait_ch1(input int k);
    int t;
    t = 0;
    while (k > 0 && t < 2000) begin
      @(posedge clock);
      t++;
      if (conv_done === 1'b1 && done_chan === 1'b0) k--;
    end
    if (t >= 2000) err_count++;
    repeat (3) @(posedge clock);
  endtask : wait_ch1

  task automatic gap(input logic ch, input int exp);
    int t;
    t = 0;
    do begin
      @(posedge clock);
      t++;
    end while (!(conv_start === 1'b1 && conv_chan === ch) && t < 2000);
    if (t >= 2000) err_count++;
    if (exp >= 0) check(16'(t), 16'(exp));
  endtask : gap

  // Seeds the filter at zero, then applies one step to 0x7000
  task automatic filt_case(input logic [7:0] cfg, input logic [15:0] exp);
    val1 = 16'h0000;
    wr(5'h10, 16'h0000);
    wait_ch1(2);
    val1 = 16'h7000;
    wr(5'h10, {8'h00, cfg});
    wait_ch1(1);
    rd(5'h00, exp);
  endtask : filt_case

  // ==========================================================================
  // Test sequence
  initial begin
    repeat (20) @(posedge clock);
    #1;
    rst = 1'b0;
    rd(5'h1E, 16'h0000);
    rd(5'h10, 16'h0000);
    rd(5'h08, 16'h0000);
    check({12'h000, range_4_20, sel_current}, 16'h0000);
    $display("test reset done");
    val1 = 16'h1234;
    val2 = 16'hEDCB;
    do @(posedge clock); while (net_sync !== 1'b1);
    gap(1'b0, 19);
    wait_ch1(2);
    rd(5'h00, 16'h1234);
    rd(5'h02, 16'hEDCB);
    val1 = 16'h8000;
    lat = 4'h9;
    n = ev_cnt;
    wait_ch1(2);
    rd(5'h00, 16'h8001);
    rd(5'h1E, 16'h0001);
    check(16'(ev_cnt - n), 16'h0001);
    wr(5'h16, 16'h1000);
    val2 = 16'h2000;
    wait_ch1(2);
    rd(5'h02, 16'h1000);
    rd(5'h1E, 16'h0009);
    open_f = 1'b1;
    wait_ch1(2);
    rd(5'h00, 16'h7FFF);
    rd(5'h1E, 16'h000F);
    open_f = 1'b0;
    inv_f = 1'b1;
    wait_ch1(2);
    rd(5'h02, 16'h8000);
    rd(5'h1E, 16'h0000);
    inv_f = 1'b0;
    wr(5'h16, 16'h7FFF);
    $display("test voltage and limits done");
    wr(5'h12, 16'h00FF);
    repeat (2) @(posedge clock);
    check({12'h000, range_4_20, sel_current}, 16'h000F);
    rd(5'h12, 16'h0000);
    val1 = 16'h4000;
    val2 = 16'h0000;
    wait_ch1(2);
    rd(5'h00, 16'h3000);
    rd(5'h02, 16'h0000);
    rd(5'h1E, 16'h0004);
    wr(5'h12, 16'h0003);
    val2 = 16'hF000;
    wait_ch1(2);
    rd(5'h02, 16'h0000);
    wr(5'h12, 16'h0033);
    wr(5'h14, 16'hE000);
    val2 = 16'hF000;
    wait_ch1(2);
    rd(5'h02, 16'hE000);
    wr(5'h12, 16'h0000);
    $display("test current ranges done");
    sync_period = 100;
    wr(5'h10, 16'h0001);
    wait_ch1(4);
    gap(1'b0, -1);
    gap(1'b1, 40);
    gap(1'b0, 160);
    #1;
    for (int i = 0; i < 14; i++) begin
      if (i < 8) begin
        filt_case(8'(i * 16 + 1),
          (i == 0 ? 16'h7000 : 16'h3FFF >> (i - 1)) >> 1);
      end else begin
        filt_case(8'(i - 6), 16'h7000 >> (i - 6));
      end
    end
    filt_case(8'hF0, 16'h7000);
    filt_case(8'h89, 16'h3800);
    sync_period = 40;
    filt_case(8'h01, 16'h7000);
    $display("test filter and ramp done");
    print_verdict();
  end
endmodule : tb_top
